/* qtm_pkg.sv */
// Package of register offsets, field positions, reset values and timing constants for the quad timer
package qtm_pkg;

  // Register word indexes (documented offsets kept as indexes, byte address is index times four)
  localparam logic [7:0] IDX_RELOAD_LOW [4] = '{8'h68, 8'h6a, 8'h76, 8'h78};
  localparam logic [7:0] IDX_RELOAD_HIGH[4] = '{8'h69, 8'h6b, 8'h77, 8'h79};
  localparam logic [7:0] IDX_COUNT_LOW  [4] = '{8'h6c, 8'h6e, 8'h7a, 8'h7c};
  localparam logic [7:0] IDX_COUNT_HIGH [4] = '{8'h6d, 8'h6f, 8'h7b, 8'h7d};
  localparam logic [7:0] IDX_MODE_CTRL  [4] = '{8'h70, 8'h72, 8'h7e, 8'h80};
  localparam logic [7:0] IDX_CLOCK_CTRL [4] = '{8'h71, 8'h73, 8'h7f, 8'h81};
  localparam logic [7:0] IDX_FLAGS      [4] = '{8'h74, 8'h75, 8'h82, 8'h83};

  // Reset values of the control and flag registers
  localparam logic [3:0] RST_MODE_CTRL  [4] = '{4'h8, 4'hc, 4'ha, 4'he};
  localparam logic [3:0] RST_CLOCK_CTRL [4] = '{4'hc, 4'hc, 4'hc, 4'hc};
  localparam logic [3:0] RST_FLAGS      [4] = '{4'hc, 4'hc, 4'he, 4'he};

  // Mode control fields
  localparam int MODE_RUN_BIT  = 0;
  localparam int MODE_CAP_BIT  = 1;
  localparam int MODE_FMEAS_BIT = 2;

  // Status fields
  localparam int FLAG_OVF_BIT = 0;
  localparam int FLAG_CAP_BIT = 1;

  // Clock select codes
  localparam logic [1:0] CSEL_SLOW = 2'h0;
  localparam logic [1:0] CSEL_FAST = 2'h1;
  localparam logic [1:0] CSEL_EXT  = 2'h2;
  localparam logic [1:0] CSEL_PAIR = 2'h3;

  // Low-speed time base derived from the 40 MHz system clock
  localparam int SYS_CLOCK_HZ   = 40000000;
  localparam int SLOW_CLOCK_MHZ_X1000 = 32768;
  localparam int SLOW_ACC_W     = 16;
  // Phase step per system cycle: 2^16 * 32768 / 40e6, rounded
  localparam logic [SLOW_ACC_W-1:0] SLOW_STEP =
    SLOW_ACC_W'((longint'(SLOW_CLOCK_MHZ_X1000) * 65536 + SYS_CLOCK_HZ / 2) / SYS_CLOCK_HZ);

  // One timer's per-cycle control view
  typedef struct packed {
    logic       run;
    logic       capture_mode;
    logic [1:0] clk_sel;
  } qtm_ctrl_s;

endpackage : qtm_pkg

/* qtm_counter.sv */
// One 8-bit timer counter with reload, capture and overflow flag
`timescale 1ns/100ps
module qtm_counter
  import qtm_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  // Control
  input  wire logic       tick_in,        // Falling edge of selected timer clock
  input  wire logic       run_in,         // Counting enabled
  input  wire logic       capture_mode_in,
  input  wire logic       capture_in,     // Capture trigger, one cycle
  input  wire logic       cap_clear_in,   // Status read clears capture flag
  // Software writes
  input  wire logic       wr_data_lo_in,
  input  wire logic       wr_data_hi_in,
  input  wire logic       wr_cnt_lo_in,
  input  wire logic       wr_cnt_hi_in,
  input  wire logic [3:0] wdata_in,
  // State
  output logic [7:0]      count_out,
  output logic [7:0]      data_out,
  output logic            ovf_flag_out,
  output logic            cap_flag_out,
  output logic            ovf_pulse_out
);

  logic [7:0] next_count;     // Counter next value
  logic [7:0] next_data;      // Data register next value
  logic       next_ovf;       // Toggling overflow flag
  logic       next_cap;       // Capture flag
  logic       next_pulse;     // Overflow event
  logic       wrap;           // Counter at all ones on a tick

  // Next-state logic for counter, data register and flags
  always_comb begin
    wrap       = tick_in && run_in && (count_out == 8'hff);
    next_count = count_out;
    next_data  = data_out;
    next_ovf   = ovf_flag_out;
    next_cap   = cap_flag_out;
    next_pulse = wrap;
    // Counting on each falling edge of the timer clock
    if (tick_in && run_in) begin                         // see [R17] [R21]
      if (wrap && !capture_mode_in) begin
        next_count = data_out;                           // see [R14]
      end else begin
        next_count = count_out + 8'h01;
      end
    end
    if (wrap) begin
      next_ovf = ~ovf_flag_out;                          // see [R8]
    end
    // Clear on read first; a capture in the same cycle is ignored while the flag is still set
    if (cap_clear_in) begin                              // see [R7]
      next_cap = 1'b0;
    end
    if (capture_in && capture_mode_in && !cap_flag_out) begin // see [R6]
      next_data = count_out;                             // see [R15]
      next_cap  = 1'b1;                                  // see [R5]
    end
    // Data writes do not touch the counter
    if (wr_data_lo_in) begin                             // see [R13] [R16]
      next_data[3:0] = wdata_in;
    end
    if (wr_data_hi_in) begin
      next_data[7:4] = wdata_in;
    end
    // Counter writes copy into the data register too
    if (wr_cnt_lo_in) begin                              // see [R19]
      next_count[3:0] = wdata_in;
      next_data[3:0]  = wdata_in;
    end
    if (wr_cnt_hi_in) begin
      next_count[7:4] = wdata_in;
      next_data[7:4]  = wdata_in;
    end
  end

  // State registers
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin                                 // see [R4]
      count_out     <= 8'h00;
      data_out      <= 8'h00;
      ovf_flag_out  <= 1'b0;
      cap_flag_out  <= 1'b0;
      ovf_pulse_out <= 1'b0;
    end else begin
      count_out     <= next_count;
      data_out      <= next_data;
      ovf_flag_out  <= next_ovf;
      cap_flag_out  <= next_cap;
      ovf_pulse_out <= next_pulse;
    end
  end

endmodule : qtm_counter

/* qtm_top.sv */
// Quad 8-bit timer with clock selection, pairing, capture and Avalon-MM register slave
`timescale 1ns/100ps

// Functional notes
// [R1] Fourth timer picks slow, fast, pin, or pair
// [R2] Software pairs third/fourth via overflow clock select
// [R3] Software waits oscillator start before fast clock
// [R4] Reset clears all status flag bits; code clears bit0 and bit1, bits 2-3 and bit1 of timers 2/3 stay one
// [R5] Capture pin change sets capture flag bit1
// [R6] Capture ignored while capture flag set
// [R7] Status read clears capture flag
// [R8] Overflow flag bit0 toggles per overflow
// [R9] Slow time base runs at 32.768 kHz
// [R10] Lower overflow clocks upper for 16 bits
// [R11] Timers 0/2 share pin a, 1/3 pin b
// [R12] External clock levels exceed one system cycle
// [R13] Data register has two writable nibbles
// [R14] Auto-reload loads data into counter on overflow
// [R15] Capture copies counter into data register
// [R16] Data write leaves counter unchanged
// [R17] Counter increments on timer clock falling edge
// [R18] Counter access while counting not guaranteed
// [R19] Counter write also writes data register
// [R20] Every overflow raises timer interrupt request
// [R21] Run bit starts/stops; lower controls pairs
// [R22] Clock select code 10 picks external pin
module qtm_top
  import qtm_pkg::*;
(
  // Clock and reset
  input  wire logic        MCLK_IN,
  input  wire logic        RST_B_IN,
  // Avalon-MM slave
  input  wire logic [9:0]  AVS_ADDRESS_IN,
  input  wire logic        AVS_READ_IN,
  input  wire logic        AVS_WRITE_IN,
  input  wire logic [31:0] AVS_WRITEDATA_IN,
  input  wire logic [3:0]  AVS_BYTEENABLE_IN,
  output logic [31:0]      AVS_READDATA_OUT,
  output logic             AVS_WAITREQUEST_OUT,
  // Clock sources
  input  wire logic        FAST_CLOCK_IN,      // High-speed clock, asynchronous
  input  wire logic        EXT_CLOCK_PIN_A_IN, // Port b bit2
  input  wire logic        EXT_CLOCK_PIN_B_IN, // Port b bit3
  // Capture inputs
  input  wire logic        PORT_B_BIT0_IN,     // Timer 0 capture
  input  wire logic        PORT_B_BIT1_IN,     // Timer 1 capture
  // Outputs
  output logic [3:0]       TIMER_IRQ_OUT,      // One-cycle overflow pulses
  output logic             T0_OVERFLOW_FLAG_OUT,
  output logic             T1_OVERFLOW_FLAG_OUT
);

  // Synchroniser chains for the asynchronous inputs
  logic [4:0] sync_a;          // First stage, read only by second stage
  logic [4:0] sync_b;          // Second stage
  logic [4:0] sync_c;          // Previous value for edge detection
  logic [4:0] next_sync_a;
  logic [4:0] next_sync_b;
  logic [4:0] next_sync_c;
  logic [4:0] raw_pins;

  // Slow time base phase accumulator
  logic [SLOW_ACC_W-1:0] slow_acc;
  logic [SLOW_ACC_W-1:0] next_slow_acc;
  logic                  slow_fall;     // Falling edge of slow clock

  // Control registers
  logic [3:0] mode_ctrl  [4];
  logic [3:0] clock_ctrl [4];
  logic [3:0] next_mode_ctrl  [4];
  logic [3:0] next_clock_ctrl [4];

  // Bus handshake state
  logic        ack;             // Answer cycle of the current request
  logic        next_ack;
  logic [31:0] rdata;
  logic [31:0] next_rdata;

  // Per-timer wiring
  qtm_ctrl_s  ctrl   [4];
  logic [3:0] tick;
  logic [3:0] ovf_pulse;
  logic [3:0] ovf_flag;
  logic [3:0] cap_flag;
  logic [7:0] count  [4];
  logic [7:0] data   [4];
  logic [3:0] ext_fall;         // Pin falling edges for each timer
  logic [3:0] capture;
  logic [3:0] cap_clear;
  logic [3:0] wr_dl;
  logic [3:0] wr_dh;
  logic [3:0] wr_cl;
  logic [3:0] wr_ch;
  logic [7:0] word_idx;         // Register index from the byte address
  logic       access;           // Request accepted this cycle
  logic       lane0;            // Low byte lane enabled
  logic       fast_fall;
  logic       pin_a_fall;
  logic       pin_b_fall;

  assign raw_pins   = {PORT_B_BIT1_IN, PORT_B_BIT0_IN, EXT_CLOCK_PIN_B_IN, EXT_CLOCK_PIN_A_IN, FAST_CLOCK_IN};
  assign word_idx   = AVS_ADDRESS_IN[9:2];
  assign access     = (AVS_READ_IN || AVS_WRITE_IN) && !ack;
  assign lane0      = AVS_BYTEENABLE_IN[0];
  // Falling edges seen after the synchroniser; pins must hold each level over a cycle
  assign fast_fall  = sync_c[0] && !sync_b[0];
  assign pin_a_fall = sync_c[1] && !sync_b[1];  // see [R12]
  assign pin_b_fall = sync_c[2] && !sync_b[2];

  // Two-stage synchroniser plus one stage of history
  always_comb begin
    next_sync_a = raw_pins;
    next_sync_b = sync_a;
    next_sync_c = sync_b;
  end

  always_ff @(posedge MCLK_IN) begin
    if (!RST_B_IN) begin
      sync_a <= 5'h00;
      sync_b <= 5'h00;
      sync_c <= 5'h00;
    end else begin
      sync_a <= next_sync_a;
      sync_b <= next_sync_b;
      sync_c <= next_sync_c;
    end
  end

  // Slow clock: accumulator MSB is the 32.768 kHz square wave
  always_comb begin
    next_slow_acc = slow_acc + SLOW_STEP;                // see [R9]
    slow_fall     = slow_acc[SLOW_ACC_W-1] && !next_slow_acc[SLOW_ACC_W-1];
  end

  always_ff @(posedge MCLK_IN) begin
    if (!RST_B_IN) begin
      slow_acc <= '0;
    end else begin
      slow_acc <= next_slow_acc;
    end
  end

  // Per-timer external clock pin: 0 and 2 share pin a, 1 and 3 share pin b
  assign ext_fall = {pin_b_fall, pin_a_fall, pin_b_fall, pin_a_fall};  // see [R11]

  // Capture events: any level change on the synchronised capture pins
  assign capture = {2'h0, sync_b[4] ^ sync_c[4], sync_b[3] ^ sync_c[3]};  // see [R5]

  // Timer instances and clock selection
  for (genvar i = 0; i < 4; i++) begin : g_timer
    logic pair_run;   // Run bit taken from the lower timer when paired
    logic paired;

    assign paired   = (i % 2 == 1) && (clock_ctrl[i][1:0] == CSEL_PAIR);
    assign pair_run = paired ? mode_ctrl[i-(i%2)][MODE_RUN_BIT] : mode_ctrl[i][MODE_RUN_BIT];  // see [R21]

    assign ctrl[i].run          = pair_run;
    assign ctrl[i].capture_mode = (i < 2) && mode_ctrl[i][MODE_CAP_BIT]
                                  && !((i == 0) && mode_ctrl[i][MODE_FMEAS_BIT]);
    assign ctrl[i].clk_sel      = clock_ctrl[i][1:0];

    // Four-way clock source select
    always_comb begin
      case (ctrl[i].clk_sel)                            // see [R1]
        CSEL_SLOW: tick[i] = slow_fall;
        CSEL_FAST: tick[i] = fast_fall;
        CSEL_EXT:  tick[i] = ext_fall[i];               // see [R22]
        CSEL_PAIR: tick[i] = (i % 2 == 1) ? ovf_pulse[i-(i%2)] : 1'b0;  // see [R10]
        default:   tick[i] = 1'b0;
      endcase
    end

    // Register strobes for this timer
    assign wr_dl[i]     = access && AVS_WRITE_IN && lane0 && (word_idx == IDX_RELOAD_LOW[i]);
    assign wr_dh[i]     = access && AVS_WRITE_IN && lane0 && (word_idx == IDX_RELOAD_HIGH[i]);
    assign wr_cl[i]     = access && AVS_WRITE_IN && lane0 && (word_idx == IDX_COUNT_LOW[i]);
    assign wr_ch[i]     = access && AVS_WRITE_IN && lane0 && (word_idx == IDX_COUNT_HIGH[i]);
    assign cap_clear[i] = access && AVS_READ_IN && (word_idx == IDX_FLAGS[i]);  // see [R7]

    qtm_counter u_counter (
      .clk_in          (MCLK_IN),
      .rst_b_in        (RST_B_IN),
      .tick_in         (tick[i]),
      .run_in          (ctrl[i].run),
      .capture_mode_in (ctrl[i].capture_mode),
      .capture_in      (capture[i]),
      .cap_clear_in    (cap_clear[i]),
      .wr_data_lo_in   (wr_dl[i]),
      .wr_data_hi_in   (wr_dh[i]),
      .wr_cnt_lo_in    (wr_cl[i]),
      .wr_cnt_hi_in    (wr_ch[i]),
      .wdata_in        (AVS_WRITEDATA_IN[3:0]),
      .count_out       (count[i]),
      .data_out        (data[i]),
      .ovf_flag_out    (ovf_flag[i]),
      .cap_flag_out    (cap_flag[i]),
      .ovf_pulse_out   (ovf_pulse[i])
    );
  end

  // Control register writes
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      next_mode_ctrl[i]  = mode_ctrl[i];
      next_clock_ctrl[i] = clock_ctrl[i];
      if (access && AVS_WRITE_IN && lane0 && (word_idx == IDX_MODE_CTRL[i])) begin
        // Bits that reset to one stay set; only the other bits take the written value
        next_mode_ctrl[i] = (AVS_WRITEDATA_IN[3:0] & ~RST_MODE_CTRL[i]) | RST_MODE_CTRL[i];
      end
      if (access && AVS_WRITE_IN && lane0 && (word_idx == IDX_CLOCK_CTRL[i])) begin
        next_clock_ctrl[i] = (AVS_WRITEDATA_IN[3:0] & ~RST_CLOCK_CTRL[i]) | RST_CLOCK_CTRL[i];
      end
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (!RST_B_IN) begin
      mode_ctrl  <= RST_MODE_CTRL;
      clock_ctrl <= RST_CLOCK_CTRL;
    end else begin
      mode_ctrl  <= next_mode_ctrl;
      clock_ctrl <= next_clock_ctrl;
    end
  end

  // Read mux and one-wait-state handshake
  always_comb begin
    next_ack   = access;
    next_rdata = 32'h0000_0000;                  // Unmapped addresses read zero
    for (int i = 0; i < 4; i++) begin
      if (word_idx == IDX_RELOAD_LOW[i])  next_rdata[3:0] = data[i][3:0];
      if (word_idx == IDX_RELOAD_HIGH[i]) next_rdata[3:0] = data[i][7:4];
      if (word_idx == IDX_COUNT_LOW[i])   next_rdata[3:0] = count[i][3:0];  // see [R18]
      if (word_idx == IDX_COUNT_HIGH[i])  next_rdata[3:0] = count[i][7:4];
      if (word_idx == IDX_MODE_CTRL[i])   next_rdata[3:0] = mode_ctrl[i];
      if (word_idx == IDX_CLOCK_CTRL[i])  next_rdata[3:0] = clock_ctrl[i];
      if (word_idx == IDX_FLAGS[i]) begin
        next_rdata[3:0]          = RST_FLAGS[i];
        next_rdata[FLAG_OVF_BIT] = ovf_flag[i];  // see [R8]
        next_rdata[FLAG_CAP_BIT] = (i < 2) ? cap_flag[i] : RST_FLAGS[i][FLAG_CAP_BIT];
      end
    end
    if (!access) begin
      next_rdata = rdata;
    end
  end

  always_ff @(posedge MCLK_IN) begin
    if (!RST_B_IN) begin
      ack   <= 1'b0;
      rdata <= 32'h0000_0000;
    end else begin
      ack   <= next_ack;
      rdata <= next_rdata;
    end
  end

  // Waitrequest drops in the answer cycle only
  assign AVS_WAITREQUEST_OUT  = !ack;
  assign AVS_READDATA_OUT     = rdata;
  assign TIMER_IRQ_OUT        = ovf_pulse;   // see [R20]
  assign T0_OVERFLOW_FLAG_OUT = ovf_flag[0];
  assign T1_OVERFLOW_FLAG_OUT = ovf_flag[1];

endmodule : qtm_top

/* qtm_cpu_model.sv */
// CPU-side Avalon-MM master model for the timer registers
`timescale 1ns/100ps
module qtm_cpu_model (
  // Clock
  input  wire logic        clk_in,
  // Master side of the register bus
  output logic [9:0]       adr_out,
  output logic             rd_out,
  output logic             wr_out,
  output logic [31:0]      wd_out,
  input  wire logic [31:0] rdat_in,
  input  wire logic        wait_in
);
  // Idle bus from time zero
  initial {adr_out, rd_out, wr_out, wd_out} = '0;

  // One transfer, held until waitrequest is seen low at a rising edge
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [3:0] d, output logic [3:0] q);
    int n;
    @(posedge clk_in);
    adr_out <= {idx, 2'h0};
    rd_out  <= ~w;
    wr_out  <= w;
    wd_out  <= {28'h0, d};
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (wait_in !== 1'b0 && n < 64);
    q = rdat_in[3:0];
    rd_out <= 1'b0;
    wr_out <= 1'b0;
    // A slave that never answers ends the run
    if (n >= 64) tb_top.hang();
  endtask : xfer
endmodule : qtm_cpu_model

/* qtm_top_chk.sv */
// Port-level assertions for the quad timer
`timescale 1ns/100ps
module qtm_top_chk (
  // Clock and reset
  input wire logic        MCLK_IN,
  input wire logic        RST_B_IN,
  // Register bus
  input wire logic        AVS_READ_IN,
  input wire logic        AVS_WRITE_IN,
  input wire logic [31:0] AVS_READDATA_OUT,
  input wire logic        AVS_WAITREQUEST_OUT,
  // Timer outputs
  input wire logic [3:0]  TIMER_IRQ_OUT,
  input wire logic        T0_OVERFLOW_FLAG_OUT,
  input wire logic        T1_OVERFLOW_FLAG_OUT
);
  // Single domain, so clock and reset are given once
  default clocking cb @(posedge MCLK_IN);
  endclocking
  default disable iff (!RST_B_IN);

  a_one_wait: assert property (
    (AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT |=> !AVS_WAITREQUEST_OUT)
    else $error("no answer after one wait state");
  a_wait_pulse: assert property (!AVS_WAITREQUEST_OUT |=> AVS_WAITREQUEST_OUT)
    else $error("answer longer than one cycle");
  a_ack_cause: assert property ($fell(AVS_WAITREQUEST_OUT) |-> $past(AVS_READ_IN || AVS_WRITE_IN))
    else $error("answer without request");
  a_rdata_pad: assert property (!AVS_WAITREQUEST_OUT |-> AVS_READDATA_OUT[31:4] == 28'h0)
    else $error("read data above nibble not zero");
  a_reset_clear: assert property ($rose(RST_B_IN) |->
    TIMER_IRQ_OUT == 4'h0 && !T0_OVERFLOW_FLAG_OUT && !T1_OVERFLOW_FLAG_OUT)
    else $error("flags not clear after reset");
  // The flag may only move together with its overflow pulse
  a_ovf_tog_t0: assert property (TIMER_IRQ_OUT[0] |-> $changed(T0_OVERFLOW_FLAG_OUT))
    else $error("timer 0 flag did not toggle");
  a_ovf_hold_t0: assert property (!TIMER_IRQ_OUT[0] |-> $stable(T0_OVERFLOW_FLAG_OUT))
    else $error("timer 0 flag moved without overflow");
  a_ovf_tog_t1: assert property (TIMER_IRQ_OUT[1] |-> $changed(T1_OVERFLOW_FLAG_OUT))
    else $error("timer 1 flag did not toggle");
  a_ovf_hold_t1: assert property (!TIMER_IRQ_OUT[1] |-> $stable(T1_OVERFLOW_FLAG_OUT))
    else $error("timer 1 flag moved without overflow");
  a_irq_pulse: assert property (|TIMER_IRQ_OUT |=> (TIMER_IRQ_OUT & $past(TIMER_IRQ_OUT)) == 4'h0)
    else $error("overflow request longer than one cycle");
endmodule : qtm_top_chk

bind qtm_top qtm_top_chk qtm_top_chk_inst (.MCLK_IN(MCLK_IN), .RST_B_IN(RST_B_IN), .AVS_READ_IN(AVS_READ_IN),
  .AVS_WRITE_IN(AVS_WRITE_IN), .AVS_READDATA_OUT(AVS_READDATA_OUT), .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT),
  .TIMER_IRQ_OUT(TIMER_IRQ_OUT), .T0_OVERFLOW_FLAG_OUT(T0_OVERFLOW_FLAG_OUT),
  .T1_OVERFLOW_FLAG_OUT(T1_OVERFLOW_FLAG_OUT));

/* tb_top.sv */
// Self-checking bench for the quad timer
`timescale 1ns/100ps
module tb_top;
  import qtm_pkg::*;
  logic        clk = 1'b0;   // 40 MHz system clock
  logic        rst_b = 1'b0; // Synchronous reset
  logic [2:0]  pins = 3'h0;  // Pin a, pin b, fast clock
  logic        cap0 = 1'b0;  // Timer 0 capture input
  logic        cap1 = 1'b0;  // Timer 1 capture input
  logic [9:0]  adr;
  logic        rdq;
  logic        wrq;
  logic [31:0] wd;
  logic [31:0] rdat;
  logic        wt;
  logic        f0;
  logic        f1;
  logic [3:0]  lo;
  logic [3:0]  hi;
  int          n_fail = 0;
  int          compares = 0;

  always #12.5 clk = ~clk;

  qtm_top qtm_top_inst (.MCLK_IN(clk), .RST_B_IN(rst_b), .AVS_ADDRESS_IN(adr), .AVS_READ_IN(rdq),
    .AVS_WRITE_IN(wrq), .AVS_WRITEDATA_IN(wd), .AVS_BYTEENABLE_IN(4'hf), .AVS_READDATA_OUT(rdat),
    .AVS_WAITREQUEST_OUT(wt), .FAST_CLOCK_IN(pins[2]), .EXT_CLOCK_PIN_A_IN(pins[0]),
    .EXT_CLOCK_PIN_B_IN(pins[1]), .PORT_B_BIT0_IN(cap0), .PORT_B_BIT1_IN(cap1), .TIMER_IRQ_OUT(),
    .T0_OVERFLOW_FLAG_OUT(f0), .T1_OVERFLOW_FLAG_OUT(f1));
  qtm_cpu_model qtm_cpu_model_inst (.clk_in(clk), .adr_out(adr), .rd_out(rdq), .wr_out(wrq),
    .wd_out(wd), .rdat_in(rdat), .wait_in(wt));

  // Verdict and end of run
  task automatic stop_test;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test

  // A bounded wait ran out
  task automatic hang;
    n_fail++;
    stop_test();
  endtask : hang

  task automatic wr(input logic [7:0] a, input logic [3:0] d);
    logic [3:0] q;
    qtm_cpu_model_inst.xfer(1'b1, a, d, q);
  endtask : wr

  // Read one register and compare
  task automatic rc(input logic [7:0] a, input logic [3:0] e);
    logic [3:0] q;
    qtm_cpu_model_inst.xfer(1'b0, a, 4'h0, q);
    compares++;
    if (q !== e) begin
      n_fail++;
      $display("mismatch reg %h expected %h seen %h", a, e, q);
    end
  endtask : rc

  task automatic ck1(input string s, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %b seen %b", s, e, g);
    end
  endtask : ck1

  // Falling edges on one clock pin, each level held four cycles
  task automatic pulses(input int k, input int n);
    repeat (n) begin
      pins[k] <= 1'b1;
      repeat (4) @(posedge clk);
      pins[k] <= 1'b0;
      repeat (4) @(posedge clk);
    end
    repeat (4) @(posedge clk);
  endtask : pulses

  // Hang guard
  initial begin
    repeat (40000) @(posedge clk);
    hang();
  end

  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    for (int t = 0; t < 4; t++) begin
      rc(IDX_RELOAD_LOW[t], 4'h0);
      rc(IDX_RELOAD_HIGH[t], 4'h0);
      rc(IDX_COUNT_LOW[t], 4'h0);
      rc(IDX_COUNT_HIGH[t], 4'h0);
      rc(IDX_MODE_CTRL[t], RST_MODE_CTRL[t]);
      rc(IDX_CLOCK_CTRL[t], RST_CLOCK_CTRL[t]);
      rc(IDX_FLAGS[t], RST_FLAGS[t]);
    end
    // Unmapped place and read-only status
    wr(8'h90, 4'h5);
    rc(8'h90, 4'h0);
    wr(8'h74, 4'h3);
    rc(8'h74, 4'hc);
    // Data writes keep the counter, counter writes copy to data
    wr(8'h68, 4'h5);
    wr(8'h69, 4'ha);
    rc(8'h68, 4'h5);
    rc(8'h69, 4'ha);
    rc(8'h6c, 4'h0);
    wr(8'h6e, 4'hf);
    wr(8'h6f, 4'hf);
    rc(8'h6a, 4'hf);
    rc(8'h6b, 4'hf);
    // External pins, wrap and reload
    wr(8'h6c, 4'he);
    wr(8'h6d, 4'hf);
    wr(8'h68, 4'h0);
    wr(8'h71, 4'h2);
    wr(8'h70, 4'h1);
    wr(8'h7f, 4'h2);
    wr(8'h7e, 4'h1);
    wr(8'h73, 4'h2);
    wr(8'h72, 4'h1);
    wr(8'h81, 4'h2);
    wr(8'h80, 4'h1);
    pulses(0, 3);
    pulses(1, 1);
    rc(8'h6c, 4'h1);
    rc(8'h6d, 4'hf);
    rc(8'h7a, 4'h3);
    rc(8'h74, 4'hd);
    ck1("t0 flag", 1'b1, f0);
    ck1("t1 flag", 1'b1, f1);
    rc(8'h6e, 4'hf);
    rc(8'h7c, 4'h1);
    // Third and fourth timers chained on the lower run bit
    wr(8'h70, 4'h0);
    wr(8'h72, 4'h0);
    wr(8'h7a, 4'hf);
    wr(8'h7b, 4'hf);
    wr(8'h76, 4'h0);
    wr(8'h7c, 4'h0);
    wr(8'h81, 4'h3);
    wr(8'h80, 4'h0);
    pulses(0, 2);
    rc(8'h7a, 4'h1);
    rc(8'h7c, 4'h1);
    rc(8'h82, 4'hf);
    rc(8'h83, 4'he);
    // Fast clock on the fourth timer; the bench oscillator is stable from the start
    wr(8'h81, 4'h1);
    wr(8'h80, 4'h1);
    wr(8'h7c, 4'h0);
    pulses(2, 3);
    rc(8'h7c, 4'h3);
    // Capture, second change ignored, read clears the flag
    wr(8'h6e, 4'h0);
    wr(8'h6f, 4'h0);
    wr(8'h72, 4'h3);
    pulses(1, 3);
    cap1 <= 1'b1;
    pulses(1, 2);
    cap1 <= 1'b0;
    repeat (8) @(posedge clk);
    rc(8'h6a, 4'h3);
    rc(8'h6b, 4'h0);
    rc(8'h75, 4'hf);
    rc(8'h75, 4'hd);
    cap1 <= 1'b1;
    repeat (8) @(posedge clk);
    rc(8'h6a, 4'h5);
    // Slow time base over 12500 cycles gives 10 or 11 ticks
    wr(8'h71, 4'h0);
    wr(8'h6c, 4'h0);
    wr(8'h6d, 4'h0);
    wr(8'h70, 4'h1);
    repeat (12500) @(posedge clk);
    wr(8'h70, 4'h0);
    qtm_cpu_model_inst.xfer(1'b0, 8'h6c, 4'h0, lo);
    qtm_cpu_model_inst.xfer(1'b0, 8'h6d, 4'h0, hi);
    ck1("slow ticks", 1'b1, {hi, lo} inside {8'h0a, 8'h0b});
    // Timer 0 capture on its own pin while the counter stands still
    wr(8'h70, 4'h2);
    cap0 <= 1'b1;
    repeat (8) @(posedge clk);
    rc(8'h68, lo);
    rc(8'h69, hi);
    // Reset in mid-run with overflow and capture flags set
    rst_b <= 1'b0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    rc(8'h74, 4'hc);
    rc(8'h75, 4'hc);
    rc(8'h82, 4'he);
    ck1("t0 flag", 1'b0, f0);
    stop_test();
  end
endmodule : tb_top
